// File: rtl/lhp_defs.vh
// Constants for the LCD host port and display RAM scan block.
// Assumes a single 20 MHz system clock samples every host and display pin.
//
// Behaviour
// RULE1 - Interface select pin picks parallel or serial.
// RULE2 - Bus family pin low selects 80-family strobes.
// RULE3 - Select and strobes classify each parallel access.
// RULE4 - Chip select inactive clears serial shifter, counter.
// RULE5 - Serial data sampled on rising clock, MSB first.
// RULE6 - Eighth serial edge delivers one parallel byte.
// RULE7 - Register select marks serial byte data or command.
// RULE8 - Host parks serial clock low between transfers.
// RULE9 - Host releases chip select after each byte.
// RULE10 - Chip select high makes all accesses ignored.
// RULE11 - Select low reaches RAM, high reaches commands.
// RULE12 - Write captured on write rise or enable fall.
// RULE13 - Writes pass a bus holder, complete next cycle.
// RULE14 - First RAM read after address set is dummy.
// RULE15 - Register read uses preloaded read address.
// RULE16 - RAM bytes addressed by column 0-F, row 0-3F.
// RULE17 - Out of range column or row addresses rejected.
// RULE18 - Auto increment advances addresses per RAM access.
// RULE19 - Start line loads on frame sync, counts lines.
// RULE20 - Row latched on line rise, shown on fall.
// RULE21 - Reverse setting inverts which RAM value lights.
// RULE22 - Alternation toggles per frame or every n lines.
// RULE23 - Slave takes alternation from master, master drives.
// RULE24 - Display modifiers act on latch, never on RAM.
// RULE25 - Serial interface supports writes only.
// RULE26 - Combined mode bumps row when column wraps.
// RULE27 - Host and line fetch never corrupt each other.
`ifndef LHP_DEFS_VH
`define LHP_DEFS_VH

// Address limits and the last serial bit count.
`define LHP_X_MAX 4'hf
`define LHP_Y_MAX 7'h42
`define LHP_Y_WRAP 7'h3f
`define LHP_Y_RAM_TOP 7'h3f
`define LHP_SER_LAST 3'h7

// Reset value of the sampled control pins (strobes and select idle high).
`define LHP_PIN_INIT 11'h160

// Command codes in the upper nibble of a command byte.
`define LHP_CMD_XLO 4'h0
`define LHP_CMD_XHI 4'h1
`define LHP_CMD_YLO 4'h2
`define LHP_CMD_YHI 4'h3
`define LHP_CMD_SLLO 4'h4
`define LHP_CMD_SLHI 4'h5
`define LHP_CMD_DISP 4'h6
`define LHP_CMD_NLINE_ALTERNATE_ENABLE 4'h7
`define LHP_CMD_NLEN 4'h8
`define LHP_CMD_RADR 4'hc
`define LHP_CMD_INC 4'hd

// Read addresses of internal registers.
`define LHP_RA_X 4'h2
`define LHP_RA_Y 4'h3
`define LHP_RA_SLLO 4'h4
`define LHP_RA_SLHI 4'h5
`define LHP_RA_NLINE_ALTERNATE_ENABLE 4'h7
`define LHP_RA_DISP 4'h8
`define LHP_RA_INC 4'ha

// Reset values.
`define LHP_RA_RESET 4'hc
`define LHP_DISP_RESET 3'h0

`endif

// File: rtl/lhp_sync.v
// Two flip-flop synchroniser for a group of asynchronous pins.
// Assumes the group's bits are independent levels; no bus coherency.
`timescale 1ns/1ps
module lhp_sync #(
  parameter W = 8,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // Clocking.
  input wire clock,
  input wire clk_en,
  input wire rst,
  // Pins in and sampled levels out.
  input wire [W-1:0] d,
  output wire [W-1:0] q
);

  // First stage; only the second stage reads it.
  reg [W-1:0] meta_q;
  // Second stage, safe for logic.
  reg [W-1:0] safe_q;

  // Both stages freeze with the clock enable like the rest of the block.
  always @(posedge clock) begin
    if (rst) begin
      meta_q <= INIT;
      safe_q <= INIT;
    end else if (clk_en) begin
      meta_q <= d;
      safe_q <= meta_q;
    end
  end

  assign q = safe_q;

endmodule // lhp_sync

// File: rtl/lhp_port.v
// Host access port, display RAM and line scan of a 128x64 LCD controller.
// Assumes every pin is asynchronous and is resampled by the 20 MHz clock,
// and that host strobes stay in each level for at least three cycles.
`timescale 1ns/1ps
`include "lhp_defs.vh"
module lhp_port #(
  parameter NLW = 4
) (
  // Clocking.
  input wire clock,
  input wire clk_en,
  input wire rst,
  // Interface configuration pins.
  input wire parallel_sel,
  input wire bus_family_select,
  input wire master_mode,
  // Host bus.
  input wire chip_select_n,
  input wire register_select,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire [7:0] data_in,
  output reg [7:0] data_out_q,
  output wire data_oe_n,
  // Serial host pins.
  input wire serial_data,
  input wire serial_clock,
  // Display timing.
  input wire line_pulse,
  input wire frame_sync,
  input wire alternate_in,
  output wire alternate_out,
  output reg [127:0] seg_data_q
);

  // Synchronised pin levels.
  wire ps_s, fam_s, cs_n_s, rs_s, rd_s, wr_s, sda_s, scl_s, lp_s, flm_s;
  wire alt_s, master_s;
  wire [7:0] din_s;

  // The master strap rides in the same group, so it is resampled too.
  lhp_sync #(.W(12), .INIT({`LHP_PIN_INIT, 1'b0})) u_pins (
    .clock(clock),
    .clk_en(clk_en),
    .rst(rst),
    .d({parallel_sel, bus_family_select, chip_select_n, register_select,
        read_strobe_n, write_strobe_n, serial_data, serial_clock,
        line_pulse, frame_sync, alternate_in, master_mode}),
    .q({ps_s, fam_s, cs_n_s, rs_s, rd_s, wr_s, sda_s, scl_s, lp_s, flm_s,
        alt_s, master_s})
  );

  lhp_sync #(.W(8), .INIT(8'h00)) u_data (
    .clock(clock),
    .clk_en(clk_en),
    .rst(rst),
    .d(data_in),
    .q(din_s)
  );

  // Previous sampled levels, for edge detection.
  reg rd_p_q, wr_p_q, scl_p_q, lp_p_q, flm_p_q;

  // Host address counters and staged upper nibbles.
  reg [3:0] x_q, x_hi_q, y_hi_q;
  reg [6:0] y_q;
  // Configuration registers written by commands.
  reg [5:0] start_q;
  reg rev_q, disp_on_q, all_on_q;
  reg [NLW-1:0] nline_q;
  reg nline_en_q;
  reg [3:0] read_addr_q;
  reg aim_q, ay_q, ax_q;
  // Bus holder.
  reg [7:0] hold_q;
  reg hold_rs_q, hold_v_q;
  // Serial shifter.
  reg [6:0] ser_q;
  reg [2:0] ser_cnt_q;
  // Prefetch buffer that makes the first read after an address set stale.
  reg [7:0] rbuf_q;
  // Display side.
  reg [5:0] line_q;
  reg [127:0] latch_q;
  reg alt_q;
  reg [NLW-1:0] alt_cnt_q;
  // Display RAM, 64 rows of 16 bytes.
  reg [7:0] ram [0:1023];

  // Parallel mode and family decode.
  wire par = ps_s; // RULE1
  wire fam80 = ~fam_s; // RULE2
  // In 68-family mode the read pin carries E and the write pin R/W.
  wire sel = par & ~cs_n_s; // RULE10
  wire e_rise = rd_s & ~rd_p_q;
  wire e_fall = ~rd_s & rd_p_q;
  // Access start and end events per family.
  wire wr_evt = sel & (fam80 ? (wr_s & ~wr_p_q) : (e_fall & ~wr_s)); // RULE12
  wire rd_go = sel & (fam80 ? (~rd_s & rd_p_q) : (e_rise & wr_s));
  wire rd_end = sel & (fam80 ? (rd_s & ~rd_p_q) : (e_fall & wr_s));
  // Reads are driven only while a read is in progress; never in serial mode.
  wire rd_act = sel & (fam80 ? ~rd_s : (rd_s & wr_s)); // RULE25
  assign data_oe_n = ~rd_act;

  // Serial clock edge; the shifter only runs in serial mode.
  wire scl_rise = ~ps_s & scl_s & ~scl_p_q;
  wire ser_done = scl_rise & ~cs_n_s & (ser_cnt_q == `LHP_SER_LAST);

  // Host RAM index and the next address after an access.
  wire y_in_ram = (y_q <= `LHP_Y_RAM_TOP);
  wire [9:0] host_idx = {y_q[5:0], x_q};
  reg [3:0] x_nx;
  reg [6:0] y_nx;

  // Increment rules: column loop, row loop, or column carry into the row.
  always @* begin
    x_nx = x_q;
    y_nx = y_q;
    if (ax_q) begin // RULE18
      x_nx = x_q + 4'h1;
      if (ay_q && x_q == `LHP_X_MAX) begin // RULE26
        y_nx = (y_q >= `LHP_Y_WRAP) ? 7'h00 : y_q + 7'h01;
      end
    end else if (ay_q) begin
      y_nx = (y_q >= `LHP_Y_WRAP) ? 7'h00 : y_q + 7'h01;
    end
  end

  // Internal register read mux, selected by the read address.
  reg [3:0] reg_rd;
  always @* begin
    case (read_addr_q) // RULE15
      `LHP_RA_X: reg_rd = x_q;
      `LHP_RA_Y: reg_rd = y_q[3:0];
      `LHP_RA_SLLO: reg_rd = start_q[3:0];
      `LHP_RA_SLHI: reg_rd = {2'h0, start_q[5:4]};
      `LHP_RA_NLINE_ALTERNATE_ENABLE: reg_rd = nline_q[3:0];
      `LHP_RA_DISP: reg_rd = {rev_q, disp_on_q, all_on_q, 1'b0};
      `LHP_RA_INC: reg_rd = {1'b0, aim_q, ay_q, ax_q};
      default: reg_rd = 4'h0;
    endcase
  end

  // Edge history registers.
  always @(posedge clock) begin
    if (rst) begin
      rd_p_q <= 1'b1;
      wr_p_q <= 1'b1;
      scl_p_q <= 1'b0;
      lp_p_q <= 1'b0;
      flm_p_q <= 1'b0;
    end else if (clk_en) begin
      rd_p_q <= rd_s;
      wr_p_q <= wr_s;
      scl_p_q <= scl_s;
      lp_p_q <= lp_s;
      flm_p_q <= flm_s;
    end
  end

  // Serial receiver: cleared while deselected, else shifts MSB first.
  always @(posedge clock) begin
    if (rst) begin
      ser_q <= 7'h00;
      ser_cnt_q <= 3'h0;
    end else if (clk_en) begin
      if (cs_n_s) begin
        ser_q <= 7'h00; // RULE4
        ser_cnt_q <= 3'h0;
      end else if (scl_rise) begin
        ser_q <= {ser_q[5:0], sda_s}; // RULE5
        ser_cnt_q <= ser_cnt_q + 3'h1; // RULE6
      end
    end
  end

  // Bus holder: catches a parallel or serial byte for the next cycle.
  always @(posedge clock) begin
    if (rst) begin
      hold_q <= 8'h00;
      hold_rs_q <= 1'b0;
      hold_v_q <= 1'b0;
    end else if (clk_en) begin
      hold_v_q <= 1'b0;
      if (wr_evt) begin // RULE13
        hold_q <= din_s;
        hold_rs_q <= rs_s; // RULE3
        hold_v_q <= 1'b1;
      end else if (ser_done) begin
        hold_q <= {ser_q, sda_s}; // RULE6
        hold_rs_q <= rs_s; // RULE7
        hold_v_q <= 1'b1;
      end
    end
  end

  // Holder commit: the write lands in RAM or a command register.
  wire cmt_ram = hold_v_q & ~hold_rs_q; // RULE11
  wire cmt_cmd = hold_v_q & hold_rs_q;
  wire [3:0] op = hold_q[7:4];
  wire [3:0] arg = hold_q[3:0];
  wire [6:0] y_cand = {y_hi_q[2:0], arg};
  // A display read that ends steps the address unless writes-only is set.
  wire rd_step = rd_end & ~rs_s & ~aim_q & ~hold_v_q; // RULE18

  // RAM write port. Rows past the array are accepted as addresses only.
  always @(posedge clock) begin
    if (clk_en && cmt_ram && y_in_ram) begin
      ram[host_idx] <= hold_q; // RULE27
    end
  end

  // Command registers and host address counters.
  always @(posedge clock) begin
    if (rst) begin
      x_q <= 4'h0;
      x_hi_q <= 4'h0;
      y_q <= 7'h00;
      y_hi_q <= 4'h0;
      start_q <= 6'h00;
      {rev_q, disp_on_q, all_on_q} <= `LHP_DISP_RESET;
      nline_q <= {NLW{1'b0}};
      nline_en_q <= 1'b0;
      read_addr_q <= `LHP_RA_RESET;
      {aim_q, ay_q, ax_q} <= 3'h0;
    end else if (clk_en) begin
      if (cmt_ram || rd_step) begin
        x_q <= x_nx;
        y_q <= y_nx;
      end else if (cmt_cmd) begin
        case (op)
          // Column set takes effect only if the full value is 00H-0FH.
          `LHP_CMD_XLO: begin
            if (x_hi_q == 4'h0) begin // RULE17
              x_q <= arg; // RULE16
            end
          end
          `LHP_CMD_XHI: x_hi_q <= arg;
          // Row set takes effect only if the full value is 00H-42H.
          `LHP_CMD_YLO: begin
            if (y_hi_q[3] == 1'b0 && y_cand <= `LHP_Y_MAX) begin // RULE17
              y_q <= y_cand; // RULE16
            end
          end
          `LHP_CMD_YHI: y_hi_q <= arg;
          `LHP_CMD_SLLO: start_q[3:0] <= arg;
          `LHP_CMD_SLHI: start_q[5:4] <= arg[1:0];
          `LHP_CMD_DISP: {rev_q, disp_on_q, all_on_q} <= arg[3:1];
          `LHP_CMD_NLINE_ALTERNATE_ENABLE: nline_q <= arg[NLW-1:0];
          `LHP_CMD_NLEN: nline_en_q <= arg[0];
          `LHP_CMD_RADR: read_addr_q <= arg; // RULE15
          `LHP_CMD_INC: {aim_q, ay_q, ax_q} <= arg[2:0];
          default: ;
        endcase
      end
    end
  end

  // Read path. The buffer reloads at each RAM read's end, so a read right
  // after an address set returns what the buffer held before.
  always @(posedge clock) begin
    if (rst) begin
      rbuf_q <= 8'h00;
      data_out_q <= 8'h00;
    end else if (clk_en) begin
      if (rd_go) begin
        // Register reads return the selected register in the low nibble.
        data_out_q <= rs_s ? {4'h0, reg_rd} : rbuf_q; // RULE14
      end
      if (rd_end && !rs_s) begin
        rbuf_q <= y_in_ram ? ram[host_idx] : 8'h00; // RULE14
      end
    end
  end

  // Line fetch: all sixteen bytes of the current line read in parallel.
  // RAM is flip-flops, so this read never waits on or disturbs a host
  // access; a write in the same cycle is simply seen the next time that row is latched.
  wire [127:0] row_bits;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_row
      localparam [3:0] COL = gi;
      assign row_bits[127 - 8 * gi -: 8] = ram[{line_q, COL}]; // RULE27
    end
  endgenerate

  // Line edges.
  wire lp_rise = lp_s & ~lp_p_q;
  wire lp_fall = ~lp_s & lp_p_q;
  wire flm_rise = flm_s & ~flm_p_q;

  // Latch modifiers change only what the segments see.
  wire [127:0] shown = ~disp_on_q ? 128'h0 :
    all_on_q ? ~128'h0 :
    rev_q ? ~latch_q : latch_q; // RULE21

  // Line counter, line latch and segment register.
  always @(posedge clock) begin
    if (rst) begin
      line_q <= 6'h00;
      latch_q <= 128'h0;
      seg_data_q <= 128'h0;
    end else if (clk_en) begin
      // Frame sync high keeps preloading the start line.
      if (flm_s) begin
        line_q <= start_q; // RULE19
      end else if (lp_fall) begin
        line_q <= line_q + 6'h01; // RULE19
      end
      if (lp_rise) begin
        latch_q <= row_bits; // RULE20
      end
      if (lp_fall) begin
        seg_data_q <= shown; // RULE24
      end
    end
  end

  // Alternation: per frame, or every n lines with n-1 programmed.
  always @(posedge clock) begin
    if (rst) begin
      alt_q <= 1'b0;
      alt_cnt_q <= {NLW{1'b0}};
    end else if (clk_en) begin
      if (nline_en_q) begin
        if (lp_fall) begin
          if (alt_cnt_q == nline_q) begin
            alt_q <= ~alt_q; // RULE22
            alt_cnt_q <= {NLW{1'b0}};
          end else begin
            alt_cnt_q <= alt_cnt_q + {{(NLW-1){1'b0}}, 1'b1};
          end
        end
      end else begin
        alt_cnt_q <= {NLW{1'b0}};
        if (flm_rise) begin
          alt_q <= ~alt_q; // RULE22
        end
      end
    end
  end

  // A slave follows the master's alternation; a master sends its own.
  assign alternate_out = master_s ? alt_q : alt_s; // RULE23

endmodule // lhp_port

// File: sim/lhp_port_asserts.sv
// Pin-level checks for the LCD host port and line scan.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module lhp_port_chk (
  // Clocking.
  input wire clock,
  input wire clk_en,
  input wire rst,
  // Configuration.
  input wire parallel_sel,
  input wire bus_family_select,
  input wire master_mode,
  // Host bus.
  input wire chip_select_n,
  input wire register_select,
  input wire read_strobe_n,
  input wire write_strobe_n,
  input wire [7:0] data_in,
  input wire [7:0] data_out_q,
  input wire data_oe_n,
  // Serial and display pins.
  input wire serial_data,
  input wire serial_clock,
  input wire line_pulse,
  input wire frame_sync,
  input wire alternate_in,
  input wire alternate_out,
  input wire [127:0] seg_data_q
);
  // Four samples cover the two-stage pin synchroniser lag.
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  property p_oe_serial;
    (!parallel_sel)[*4] |-> data_oe_n;
  endproperty
  a_oe_serial: assert property (p_oe_serial)
    else $error("Bus driven in serial mode");
  property p_oe_cs;
    chip_select_n[*4] |-> data_oe_n;
  endproperty
  a_oe_cs: assert property (p_oe_cs)
    else $error("Bus driven while deselected");
  property p_oe_read;
    (parallel_sel && !bus_family_select && !chip_select_n &&
      !read_strobe_n)[*4] |-> !data_oe_n;
  endproperty
  a_oe_read: assert property (p_oe_read)
    else $error("Read strobe not answered");
  property p_oe_68;
    (parallel_sel && bus_family_select && !chip_select_n &&
      read_strobe_n && write_strobe_n)[*4] |-> !data_oe_n;
  endproperty
  a_oe_68: assert property (p_oe_68)
    else $error("Enable read not answered");
  property p_oe_write;
    (parallel_sel && !bus_family_select && read_strobe_n)[*4] |-> data_oe_n;
  endproperty
  a_oe_write: assert property (p_oe_write)
    else $error("Bus driven without read strobe");
  property p_rd_end;
    $rose(read_strobe_n) && !bus_family_select |-> ##[1:4] data_oe_n;
  endproperty
  a_rd_end: assert property (p_rd_end)
    else $error("Bus not released after read");
  property p_seg;
    $stable(line_pulse)[*6] |-> $stable(seg_data_q);
  endproperty
  a_seg: assert property (p_seg)
    else $error("Segments changed without line pulse");
  property p_alt_hold;
    $stable({line_pulse, frame_sync, master_mode, alternate_in})[*6]
      |-> $stable(alternate_out);
  endproperty
  a_alt_hold: assert property (p_alt_hold)
    else $error("Alternation moved without cause");
  property p_alt_slave;
    (!master_mode && $stable(alternate_in))[*4]
      |-> alternate_out == alternate_in;
  endproperty
  a_alt_slave: assert property (p_alt_slave)
    else $error("Slave alternation not followed");
endmodule // lhp_port_chk

// File: sim/lhp_host.sv
// Behavioural 8-bit host driving the block's parallel and serial pins.
// Assumes the bench clock paces each strobe phase at four cycles, an active read strobe at six.
`timescale 1ns/1ps
module lhp_host (
  // Pacing clock.
  input wire clock,
  // Read data from the block.
  input wire [7:0] data_out_q,
  // Host pins.
  output reg chip_select_n,
  output reg register_select,
  output reg read_strobe_n,
  output reg write_strobe_n,
  output reg [7:0] data_in,
  output reg serial_data,
  output reg serial_clock
);
  // Idle: deselected, strobes parked, serial clock low.
  initial begin
    chip_select_n = 1'b1;
    register_select = 1'b0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    data_in = 8'h00;
    serial_data = 1'b0;
    serial_clock = 1'b0;
  end
  // Pins only change just after a rising edge.
  task tick(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // Parallel write; f set selects enable and read/write signalling.
  task wr(input f, input rs, input [7:0] d);
    begin
      tick(1);
      chip_select_n <= 1'b0;
      register_select <= rs;
      data_in <= d;
      write_strobe_n <= 1'b0;
      read_strobe_n <= 1'b1;
      tick(4);
      read_strobe_n <= ~f; // Enable falls, or write strobe rises.
      write_strobe_n <= ~f;
      tick(4);
      chip_select_n <= 1'b1;
      data_in <= ~d; // A released bus must not show the old byte.
      write_strobe_n <= 1'b1;
      tick(4);
    end
  endtask
  // Parallel read; the byte is taken just before the strobe ends.
  task rd(input f, input rs, output [7:0] d);
    begin
      tick(1);
      chip_select_n <= 1'b0;
      register_select <= rs;
      read_strobe_n <= f;
      tick(6);
      d = data_out_q;
      read_strobe_n <= ~f;
      tick(4);
      chip_select_n <= 1'b1;
      tick(4);
    end
  endtask
  // Serial byte, most significant bit first, 400 ns clock period.
  task ser(input rs, input [7:0] d);
    integer i;
    begin
      tick(1);
      chip_select_n <= 1'b0;
      register_select <= rs;
      for (i = 7; i >= 0; i = i - 1) begin
        serial_data <= d[i];
        tick(4);
        serial_clock <= 1'b1;
        tick(4);
        serial_clock <= 1'b0;
      end
      serial_data <= ~d[0];
      tick(4);
      chip_select_n <= 1'b1;
      tick(4);
    end
  endtask
endmodule // lhp_host

// File: sim/test_lhp_port.sv
// Self-checking bench for the LCD host port, serial input and line scan.
// Assumes lhp_host paces the host pins and the bench the display pins.
`timescale 1ns/1ps
module test_lhp_port;
  // Bench-driven clock, reset and configuration.
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg parallel_sel = 1'b1;
  reg bus_family_select = 1'b0;
  reg master_mode = 1'b0;
  reg line_pulse = 1'b0;
  reg frame_sync = 1'b0;
  reg alternate_in = 1'b1;
  // Host pins and block outputs.
  wire chip_select_n, register_select, read_strobe_n, write_strobe_n;
  wire serial_data, serial_clock, data_oe_n, alternate_out;
  wire [7:0] data_in;
  wire [7:0] data_out_q;
  wire [127:0] seg_data_q;
  // Counters and scratch values.
  integer errors = 0;
  integer total_checks = 0;
  reg [7:0] rdat;
  reg alt0;

  always #25 clock = ~clock;

  lhp_host host (.clock(clock), .data_out_q(data_out_q),
    .chip_select_n(chip_select_n), .register_select(register_select),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .data_in(data_in), .serial_data(serial_data),
    .serial_clock(serial_clock));
  lhp_port dut (.clock(clock), .clk_en(1'b1), .rst(rst),
    .parallel_sel(parallel_sel), .bus_family_select(bus_family_select),
    .master_mode(master_mode), .chip_select_n(chip_select_n),
    .register_select(register_select), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_in(data_in),
    .data_out_q(data_out_q), .data_oe_n(data_oe_n),
    .serial_data(serial_data), .serial_clock(serial_clock),
    .line_pulse(line_pulse), .frame_sync(frame_sync),
    .alternate_in(alternate_in), .alternate_out(alternate_out),
    .seg_data_q(seg_data_q));

  // Compares one byte and reports a mismatch at once.
  task chk(input [63:0] name, input [7:0] exp, input [7:0] got);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR %0s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  // One line period; with f set, frame sync holds the row at start line.
  task line(input f);
    begin
      @(posedge clock);
      frame_sync <= f;
      repeat (6) @(posedge clock);
      line_pulse <= 1'b1;
      repeat (6) @(posedge clock);
      line_pulse <= 1'b0;
      repeat (8) @(posedge clock);
      frame_sync <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  // RAM writes with column stepping, then dummy and real reads.
  task t_ram;
    begin
      host.wr(0, 1, 8'hd1);
      host.wr(0, 1, 8'h10);
      host.wr(0, 1, 8'h03);
      host.wr(0, 1, 8'h25);
      host.wr(0, 0, 8'ha5);
      host.wr(0, 0, 8'h5a);
      host.wr(0, 1, 8'h03);
      host.rd(0, 0, rdat);
      host.rd(0, 0, rdat);
      chk("ram0", 8'ha5, rdat);
      host.rd(0, 0, rdat);
      chk("ram1", 8'h5a, rdat);
    end
  endtask
  // Out-of-range addresses are refused; registers read back indirectly.
  task t_reg;
    begin
      host.wr(0, 1, 8'h11);
      host.wr(0, 1, 8'h02);
      host.wr(0, 1, 8'h10);
      host.wr(0, 1, 8'h34);
      host.wr(0, 1, 8'h23);
      host.wr(0, 1, 8'h30);
      host.wr(0, 1, 8'hc2);
      host.rd(0, 1, rdat);
      chk("col", 8'h06, rdat);
      host.wr(0, 1, 8'hc3);
      host.rd(0, 1, rdat);
      chk("row", 8'h05, rdat);
    end
  endtask
  // Enable and read/write signalling for write and read.
  task t_68;
    begin
      @(posedge clock);
      bus_family_select <= 1'b1;
      host.wr(1, 1, 8'hc2);
      host.rd(1, 1, rdat);
      chk("fam68", 8'h06, rdat);
      @(posedge clock);
      bus_family_select <= 1'b0;
    end
  endtask
  // Serial column set, then checked over the parallel bus.
  task t_ser;
    begin
      @(posedge clock);
      parallel_sel <= 1'b0;
      host.ser(1, 8'h10);
      host.ser(1, 8'h09);
      @(posedge clock);
      parallel_sel <= 1'b1;
      host.wr(0, 1, 8'hc2);
      host.rd(0, 1, rdat);
      chk("serial", 8'h09, rdat);
    end
  endtask
  // Line latch, reverse, alternation, and RAM left untouched.
  task t_disp;
    begin
      host.wr(0, 1, 8'hd0);
      host.wr(0, 1, 8'h00);
      host.wr(0, 1, 8'h20);
      host.wr(0, 0, 8'h81);
      host.wr(0, 1, 8'h64);
      @(posedge clock);
      master_mode <= 1'b1;
      repeat (4) @(posedge clock);
      alt0 = alternate_out;
      line(1'b1);
      chk("seg", 8'h81, seg_data_q[127:120]);
      chk("alt", {7'h00, ~alt0}, {7'h00, alternate_out});
      host.wr(0, 1, 8'h6c);
      line(1'b1);
      chk("reverse", 8'h7e, seg_data_q[127:120]);
      host.wr(0, 1, 8'h00);
      host.rd(0, 0, rdat);
      host.rd(0, 0, rdat);
      chk("ramkeep", 8'h81, rdat);
    end
  endtask
  // Combined stepping, start line scroll, n-line alternation, all-on.
  task t_scan;
    begin
      host.wr(0, 1, 8'hd3);
      host.wr(0, 1, 8'h0f);
      host.wr(0, 1, 8'h21);
      host.wr(0, 0, 8'h3c);
      host.wr(0, 0, 8'hc3);
      host.wr(0, 1, 8'hc3);
      host.rd(0, 1, rdat);
      chk("rowwrap", 8'h02, rdat);
      host.wr(0, 1, 8'hc2);
      host.rd(0, 1, rdat);
      chk("colwrap", 8'h01, rdat);
      host.wr(0, 1, 8'h64);
      host.wr(0, 1, 8'h41);
      host.wr(0, 1, 8'h71);
      host.wr(0, 1, 8'h81);
      alt0 = alternate_out;
      line(1'b1);
      chk("start", 8'h3c, seg_data_q[7:0]);
      line(1'b0);
      chk("nline", {7'h00, ~alt0}, {7'h00, alternate_out});
      line(1'b0);
      chk("count", 8'hc3, seg_data_q[127:120]);
      host.wr(0, 1, 8'h66);
      line(1'b0);
      chk("allon", 8'hff, seg_data_q[15:8]);
    end
  endtask
  // Prints the counts and the verdict, then ends the run.
  task finish_test;
    begin
      $display("Checks %0d, errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    t_ram;
    t_reg;
    t_68;
    t_ser;
    t_disp;
    t_scan;
    finish_test;
  end
endmodule // test_lhp_port

bind lhp_port lhp_port_chk chk (.clock(clock), .clk_en(clk_en), .rst(rst),
  .parallel_sel(parallel_sel), .bus_family_select(bus_family_select),
  .master_mode(master_mode), .chip_select_n(chip_select_n),
  .register_select(register_select), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .data_in(data_in),
  .data_out_q(data_out_q), .data_oe_n(data_oe_n),
  .serial_data(serial_data), .serial_clock(serial_clock),
  .line_pulse(line_pulse), .frame_sync(frame_sync),
  .alternate_in(alternate_in), .alternate_out(alternate_out),
  .seg_data_q(seg_data_q));
